// File: rtl/ppp_pkg.sv
// Constants for the byte-wide PROM programming port controller
// Assumes a 10 MHz core clock; times are converted to cycle counts here
package ppp_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned PULSE_MIN_NS  = 190000;   // 0.19 ms
  localparam int unsigned PULSE_MAX_NS  = 210000;   // 0.21 ms
  localparam int unsigned OVR_MAX_NS    = 5250000;  // 5.25 ms
  localparam int unsigned SETUP_NS      = 2000;     // 2 us setups and holds
  localparam int unsigned FLOAT_NS      = 130000;   // 130 us output float
  localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
  // Initial pulse: midpoint 0.20 ms, inside the window
  localparam int unsigned PULSE_CYC     = (PULSE_MIN_NS + PULSE_MAX_NS) / (2 * CLK_NS);
  localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FLOAT_CYC     = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OVR_MAX_CYC   = OVR_MAX_NS / CLK_NS;
  localparam int unsigned MAX_TRIES     = 25;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [16:0] ADDR_FIRST    = 17'h00000;
  localparam logic [16:0] ADDR_LAST     = 17'h0edff;
  localparam logic [16:0] ADDR_GUARD    = 17'h0ee00;
  localparam logic [16:0] ADDR_TOP      = 17'h1ffff;
  localparam logic [7:0]  BLANK_BYTE    = 8'hff;
  localparam int          CNT_W         = 16;
  localparam int          TRY_W         = 5;
endpackage

// File: rtl/ppp_timer.sv
// Down-counter that pulses done after a loaded number of cycles
// Assumes one clock domain, asynchronous active-high reset
`timescale 1ns/10ps
module ppp_timer
  import ppp_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output      logic             done
);
  logic [CNT_W-1:0] cnt_q;
  logic             run_q;
  wire              last = run_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 1'b1;
      run_q <= !last;
    end
  end

  assign done = last;
endmodule // ppp_timer

// File: rtl/ppp_host.sv
// Programmer side of the byte-wide PROM port: write, verify, overwrite
// Assumes the device sits in PROM mode and its data inputs are synchronous
`timescale 1ns/10ps
module ppp_host
  import ppp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,
  input  wire logic        req_verify_only,
  input  wire logic [16:0] req_addr,
  input  wire logic [7:0]  req_data,
  output      logic        req_ready,
  output      logic        rsp_valid,
  output      logic        rsp_ok,
  output      logic [7:0]  rsp_data,
  output      logic        chip_enable_low,
  output      logic        output_gate_low,
  output      logic        program_strobe_low,
  output      logic [16:0] prom_address_lines,
  output      logic [7:0]  prom_data_lines_o,
  output      logic        prom_data_lines_oe,
  input  wire logic [7:0]  prom_data_lines_i,
  output      logic        mode_select_pin,
  output      logic        mode_pair_low,
  output      logic        mode_pair_high
);
  typedef enum logic [2:0] {
    PPP_IDLE  = 3'b000,
    PPP_SETUP = 3'b001,
    PPP_PULSE = 3'b011,
    PPP_HOLD  = 3'b010,
    PPP_VFY   = 3'b110,
    PPP_FLOAT = 3'b111,
    PPP_DONE  = 3'b101
  } ppp_state_t;

  ppp_state_t       st_q, st_d;
  logic [TRY_W-1:0] try_q;
  logic             ovr_q, vonly_q, ok_q;
  logic [7:0]       wdat_q, rdat_q;
  logic             tload;
  logic [CNT_W-1:0] tcount;
  logic             tdone;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire in_range  = req_addr <= ADDR_LAST;
  wire guarded   = req_addr >= ADDR_GUARD;
  wire take      = (st_q == PPP_IDLE) && req_valid;
  // Writes that need no pulse finish at once
  wire skip      = take && !req_verify_only && (guarded || !in_range
                   || req_data == BLANK_BYTE);
  wire match     = prom_data_lines_i == wdat_q;
  wire give_up   = try_q == TRY_W'(MAX_TRIES);

  // Overwrite length: three initial pulses per try, worked out wide
  // so the product cannot wrap before the cap is applied
  wire [31:0]      ovr_full = 32'(PULSE_CYC) * 32'(try_q) * 32'h3;
  wire             ovr_cap  = ovr_full > 32'(OVR_MAX_CYC);
  wire [CNT_W-1:0] ovr_cnt  = ovr_cap ? CNT_W'(OVR_MAX_CYC)
                              : ovr_full[CNT_W-1:0];

  // Phase timer, reloaded on entry to each timed phase
  ppp_timer u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (tload),
    .count    (tcount),
    .done     (tdone)
  );

  // ----------------------------------------------------------------
  // Sequencer: setup, pulse, hold, verify, float
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    tload  = 1'b0;
    tcount = CNT_W'(SETUP_CYC);
    unique case (st_q)
      PPP_IDLE: begin
        if (take && !skip) begin
          st_d  = req_verify_only ? PPP_VFY : PPP_SETUP;
          tload = 1'b1;
        end else if (skip) begin
          st_d = PPP_DONE;
        end
      end
      PPP_SETUP: begin
        if (tdone) begin
          st_d   = PPP_PULSE;
          tload  = 1'b1;
          tcount = ovr_q ? ovr_cnt : CNT_W'(PULSE_CYC);
        end
      end
      PPP_PULSE: begin
        if (tdone) begin
          st_d  = PPP_HOLD;
          tload = 1'b1;
        end
      end
      PPP_HOLD: begin
        if (tdone) begin
          st_d  = ovr_q ? PPP_DONE : PPP_VFY;
          tload = !ovr_q;
        end
      end
      PPP_VFY: begin
        if (tdone) begin
          st_d   = PPP_FLOAT;
          tload  = 1'b1;
          tcount = CNT_W'(FLOAT_CYC);
        end
      end
      PPP_FLOAT: begin
        if (tdone) begin
          if (vonly_q || !ok_q && give_up) begin
            st_d = PPP_DONE;
          end else begin
            st_d  = PPP_SETUP;
            tload = 1'b1;
          end
        end
      end
      PPP_DONE: st_d = PPP_IDLE;
      default:  st_d = PPP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State and request registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= PPP_IDLE;
      try_q   <= '0;
      ovr_q   <= 1'b0;
      vonly_q <= 1'b0;
      ok_q    <= 1'b0;
      wdat_q  <= '0;
      rdat_q  <= '0;
    end else begin
      st_q <= st_d;
      // Latch a new request
      if (take) begin
        try_q   <= '0;
        ovr_q   <= 1'b0;
        vonly_q <= req_verify_only;
        ok_q    <= skip;
        wdat_q  <= req_data;
      end
      // Count tries and capture the verify byte
      if (st_q == PPP_SETUP && tdone && !ovr_q) try_q <= try_q + 1'b1;
      if (st_q == PPP_VFY && tdone) begin
        rdat_q <= prom_data_lines_i;
        ok_q   <= match;
      end
      // Matched: the next pulse is the overwrite
      if (st_q == PPP_FLOAT && tdone && ok_q && !vonly_q) ovr_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next pin levels, decoded from the next state
  // ----------------------------------------------------------------
  wire ce_d    = st_d == PPP_IDLE || st_d == PPP_DONE;
  wire pgm_d   = st_d != PPP_PULSE;
  wire gate_d  = st_d != PPP_VFY;
  wire drive_d = st_d == PPP_SETUP || st_d == PPP_PULSE
                 || st_d == PPP_HOLD;
  wire ready_d = st_d == PPP_IDLE && !take;

  // ----------------------------------------------------------------
  // Pin drivers, registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_enable_low    <= 1'b1;
      output_gate_low    <= 1'b1;
      program_strobe_low <= 1'b1;
      prom_address_lines <= ADDR_FIRST;
      prom_data_lines_o  <= '0;
      prom_data_lines_oe <= 1'b0;
      req_ready          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_ok             <= 1'b0;
      rsp_data           <= '0;
      mode_select_pin    <= 1'b0;
      mode_pair_low      <= 1'b1;
      mode_pair_high     <= 1'b0;
    end else begin
      // PROM-mode levels on the mode pins
      mode_select_pin    <= 1'b1;
      mode_pair_low      <= 1'b0;
      mode_pair_high     <= 1'b1;
      // One byte and its address per request
      if (take) prom_address_lines <= req_addr;
      if (take) prom_data_lines_o  <= req_data;
      // Strobes and data drive for the next phase
      chip_enable_low    <= ce_d;
      program_strobe_low <= pgm_d;
      output_gate_low    <= gate_d;
      prom_data_lines_oe <= drive_d;
      // Request handshake and response
      req_ready          <= ready_d;
      rsp_valid          <= st_q == PPP_DONE;
      rsp_ok             <= ok_q;
      rsp_data           <= vonly_q ? rdat_q : wdat_q;
    end
  end
endmodule // ppp_host

// File: verification/ppp_monitor.sv
// Checker for the PROM port strobes and request handshake
// Assumes binding onto ppp_host; one clock, async active-high reset
`timescale 1ns/10ps
module ppp_monitor
  import ppp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic        req_verify_only,
  input wire logic [16:0] req_addr,
  input wire logic [7:0]  req_data,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_ok,
  input wire logic        chip_enable_low,
  input wire logic        output_gate_low,
  input wire logic        program_strobe_low,
  input wire logic [16:0] prom_address_lines,
  input wire logic [7:0]  prom_data_lines_o,
  input wire logic        prom_data_lines_oe,
  input wire logic        mode_select_pin,
  input wire logic        mode_pair_low,
  input wire logic        mode_pair_high
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] pw_q;
  // Cycles the program strobe has been low
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      pw_q <= 16'h0000;
    else
      pw_q <= program_strobe_low ? 16'h0000 : pw_q + 16'h0001;
  a_idle_quiet: assert property (req_ready |-> chip_enable_low && output_gate_low &&
    program_strobe_low && !prom_data_lines_oe) else $error("strobes active while idle");
  a_write_mix: assert property (!program_strobe_low |-> !chip_enable_low &&
    output_gate_low && prom_data_lines_oe) else $error("bad write strobes");
  a_verify_mix: assert property (!output_gate_low |-> !chip_enable_low &&
    program_strobe_low && !prom_data_lines_oe) else $error("bad verify strobes");
  a_pulse_width: assert property ($rose(program_strobe_low) |->
    pw_q >= 16'h076c && pw_q <= 16'hcd14) else $error("pulse width out of range");
  a_addr_window: assert property (!program_strobe_low |->
    prom_address_lines <= ADDR_LAST) else $error("pulse outside window");
  a_byte_held: assert property (!program_strobe_low && !$past(program_strobe_low) |->
    $stable(prom_address_lines) && $stable(prom_data_lines_o)) else $error("byte moved");
  a_ce_setup: assert property ($fell(program_strobe_low) |->
    !$past(chip_enable_low, 20)) else $error("enable setup short");
  a_mode_levels: assert property (!$past(sys_rst) |-> mode_select_pin &&
    !mode_pair_low && mode_pair_high) else $error("mode pins wrong");
  a_skip_quick: assert property (req_valid && req_ready && !req_verify_only &&
    (req_addr >= ADDR_GUARD || req_data == BLANK_BYTE) |=> chip_enable_low throughout
    ##[0:2] (rsp_valid && rsp_ok)) else $error("skipped write not quick");
endmodule // ppp_monitor
bind ppp_host ppp_monitor ppp_monitor_inst (.core_clk, .sys_rst, .req_valid,
  .req_verify_only, .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_ok,
  .chip_enable_low, .output_gate_low, .program_strobe_low, .prom_address_lines,
  .prom_data_lines_o, .prom_data_lines_oe, .mode_select_pin, .mode_pair_low,
  .mode_pair_high);

// File: verification/ppp_dev_model.sv
// Behavioural PROM device seen through its byte programming port
// Assumes strobes and mode pins come straight from the host; no clock
`timescale 1ns/10ps
module ppp_dev_model (
  input  wire logic        chip_enable_low,
  input  wire logic        output_gate_low,
  input  wire logic        program_strobe_low,
  input  wire logic [16:0] prom_address_lines,
  input  wire logic [7:0]  prom_data_lines_i,
  input  wire logic        mode_select_pin,
  input  wire logic        mode_pair_low,
  input  wire logic        mode_pair_high,
  input  wire logic        slow,
  output      logic [7:0]  dev_data,
  output      logic        dev_drive
);
  logic [7:0] mem [0:131071];
  logic       en;
  logic       pend;
  logic       broken;
  // Erased array reads all ones
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    pend = 1'b0;
    broken = 1'b0;
  end
  // Port alive only in PROM mode; verify decode, else released
  assign en = mode_select_pin && !mode_pair_low && mode_pair_high;
  assign dev_drive = en && !chip_enable_low && !output_gate_low && program_strobe_low;
  assign dev_data = (dev_drive && !broken) ? mem[prom_address_lines] :
                    ~mem[prom_address_lines];
  // One byte per pulse; when slow, every other pulse is ignored, starting with the first
  always @(posedge program_strobe_low) begin
    if (en && !chip_enable_low && output_gate_low) begin
      if (prom_address_lines > 17'h0edff)
        broken = 1'b1;
      if (slow && !pend)
        pend = 1'b1;
      else begin
        mem[prom_address_lines] = mem[prom_address_lines] & prom_data_lines_i;
        pend = 1'b0;
      end
    end
  end
endmodule // ppp_dev_model

// File: verification/tb_prom_byte_programming_port.sv
// Testbench for the PROM programming port controller
// Assumes ppp_host, ppp_dev_model and the bound checker
`timescale 1ns/10ps
module tb_prom_byte_programming_port;
  import ppp_pkg::*;
  logic        core_clk, sys_rst, req_valid, req_verify_only, req_ready, rsp_valid, rsp_ok;
  logic        chip_enable_low, output_gate_low, program_strobe_low, prom_data_lines_oe;
  logic        mode_select_pin, mode_pair_low, mode_pair_high, slow, dev_drive, ce_seen;
  logic [16:0] req_addr, prom_address_lines;
  logic [7:0]  req_data, rsp_data, prom_data_lines_o, prom_data_lines_i, dev_data, got;
  int          n_errors, n_compared;
  assign prom_data_lines_i = prom_data_lines_oe ? prom_data_lines_o : dev_data;
  ppp_host ppp_host_inst (.core_clk, .sys_rst, .req_valid, .req_verify_only, .req_addr,
    .req_data, .req_ready, .rsp_valid, .rsp_ok, .rsp_data, .chip_enable_low,
    .output_gate_low, .program_strobe_low, .prom_address_lines, .prom_data_lines_o,
    .prom_data_lines_oe, .prom_data_lines_i, .mode_select_pin, .mode_pair_low,
    .mode_pair_high);
  ppp_dev_model ppp_dev_model_inst (.chip_enable_low, .output_gate_low,
    .program_strobe_low, .prom_address_lines, .prom_data_lines_i, .mode_select_pin,
    .mode_pair_low, .mode_pair_high, .slow, .dev_data, .dev_drive);
  // Notes any enable strobe
  always @(negedge chip_enable_low) ce_seen = 1'b1;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One request, driven for one cycle once ready is high, then wait for the response
  task automatic req(input logic vo, input logic [16:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    req_valid = 1'b1;
    req_verify_only = vo;
    req_addr = a;
    req_data = d;
    @(negedge core_clk);
    req_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 30000) begin
      @(negedge core_clk);
      k++;
    end
    got = rsp_data;
    chk(rsp_valid, 1'b1);
  endtask
  task automatic t_write(input logic s, input logic [16:0] a, input logic [7:0] d);
    slow = s;
    req(1'b0, a, d);
    chk(rsp_ok, 1'b1);
    chk(got, d);
    req(1'b1, a, 8'h00);
    chk(got, d);
    slow = 1'b0;
    $display("test write %h done", a);
  endtask
  task automatic t_skip(input logic [16:0] a, input logic [7:0] d);
    ce_seen = 1'b0;
    req(1'b0, a, d);
    chk(rsp_ok, 1'b1);
    chk(ce_seen, 1'b0);
    req(1'b1, a, 8'h00);
    chk(got, 8'hff);
    chk(dev_drive, 1'b0);
    $display("test skip %h done", a);
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {sys_rst, req_valid, req_verify_only, slow, ce_seen} = 5'h10;
    {req_addr, req_data} = 25'h0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    t_write(1'b0, ADDR_FIRST, 8'h5a);
    t_write(1'b1, ADDR_LAST, 8'h3c);
    t_skip(ADDR_GUARD, 8'h00);
    t_skip(17'h00005, BLANK_BYTE);
    report_and_stop();
  end
  initial begin
    #6000000;
    n_errors++;
    report_and_stop();
  end
endmodule // tb_prom_byte_programming_port
